// file: include/vsc_pkg.sv
/*
 * Package for the vram strobe configuration selector: register map, option
 * field positions, reset values, configuration codes and timing counts.
 * Assumes a 200 MHz system clock and an APB slave with 32-bit data.
 */
package vsc_pkg;
   // register byte addresses
   localparam logic [11:0] OptionsAddr = 12'h000;
   localparam logic [11:0] StatusAddr = 12'h004;

   // field positions in the options register
   localparam int ConfigLsb = 0;
   localparam int ColumnSetupBit = 3;
   localparam int RowHoldBit = 4;
   localparam int WriteStrobeBit = 5;
   localparam int OptionsWidth = 6;
   localparam logic [5:0] OptionsReset = 6'h00;

   // status register field positions
   localparam int StatusProgBit = 0;
   localparam int StatusScrubBit = 1;
   localparam int StatusRasLsb = 4;
   localparam int StatusCasLsb = 8;

   // strobe configuration codes
   typedef enum logic [2:0] {
      CfgAllScrub = 3'b000,
      CfgPairs = 3'b001,
      CfgSingles = 3'b010,
      CfgAllRasOnly = 3'b011
   } vsc_config_t;

   // timing in nanoseconds and derived cycle counts at 5 ns
   localparam int ClkPeriodPs = 5000;
   localparam int RowHoldLongNs = 25;
   localparam int RowHoldShortNs = 15;
   localparam int ColSetupLongNs = 10;
   localparam int ColSetupShortNs = 0;
   // least times round up, and never below one cycle
   localparam int RowHoldLongCyc = ((RowHoldLongNs * 1000 + ClkPeriodPs - 1) / ClkPeriodPs) < 1 ? 1 :
      ((RowHoldLongNs * 1000 + ClkPeriodPs - 1) / ClkPeriodPs);
   localparam int RowHoldShortCyc = ((RowHoldShortNs * 1000 + ClkPeriodPs - 1) / ClkPeriodPs) < 1 ? 1 :
      ((RowHoldShortNs * 1000 + ClkPeriodPs - 1) / ClkPeriodPs);
   localparam int ColSetupLongCyc = ((ColSetupLongNs * 1000 + ClkPeriodPs - 1) / ClkPeriodPs) < 1 ? 1 :
      ((ColSetupLongNs * 1000 + ClkPeriodPs - 1) / ClkPeriodPs);
   localparam int ColSetupShortCyc = ((ColSetupShortNs * 1000 + ClkPeriodPs - 1) / ClkPeriodPs) < 1 ? 1 :
      ((ColSetupShortNs * 1000 + ClkPeriodPs - 1) / ClkPeriodPs);
   localparam int CountWidth = 4;
endpackage

// file: rtl/vsc_strobe_decode.sv
/*
 * Combinational strobe decoder: from the configuration code and the two
 * bank-select inputs works out which row and column strobes an access uses
 * and whether refresh scrubs. Assumes inputs are stable during an access.
 */
module vsc_strobe_decode (
   input wire logic [2:0] configCode,
   input wire logic bankSelectLow,
   input wire logic bankSelectHigh,
   output logic [3:0] rowSelect,
   output logic [3:0] colSelect,
   output logic scrubRefresh
);
   always_comb begin
      rowSelect = 4'h0;
      colSelect = 4'h0;
      scrubRefresh = 1'b0;
      case (configCode)
         vsc_pkg::CfgAllScrub: begin
            rowSelect = 4'hF;
            colSelect = 4'hF;
            scrubRefresh = 1'b1;
         end
         vsc_pkg::CfgPairs: begin
            rowSelect = bankSelectHigh ? 4'hC : 4'h3;
            colSelect = bankSelectHigh ? 4'hC : 4'h3;
            scrubRefresh = 1'b1;
         end
         vsc_pkg::CfgSingles: begin
            rowSelect = 4'h1 << {bankSelectHigh, bankSelectLow};
            colSelect = 4'h1 << {bankSelectHigh, bankSelectLow};
            scrubRefresh = 1'b1;
         end
         vsc_pkg::CfgAllRasOnly: begin
            rowSelect = 4'hF;
            colSelect = 4'hF;
            scrubRefresh = 1'b0;
         end
         // codes outside this block's scope select nothing
         default: begin
            rowSelect = 4'h0;
            colSelect = 4'h0;
            scrubRefresh = 1'b0;
         end
      endcase
   end
endmodule

// file: rtl/vsc_delay_count.sv
/*
 * Small down-counter that times a minimum interval in clock cycles after a
 * start pulse; done is high once the interval has elapsed. Assumes one clock.
 */
module vsc_delay_count (
   input wire logic clk_sys,
   input wire logic sys_rst,
   input wire logic start,
   input wire logic [vsc_pkg::CountWidth-1:0] cycles,
   output logic done
);
   logic [vsc_pkg::CountWidth-1:0] count_q;
   logic [vsc_pkg::CountWidth-1:0] count_d;
   logic done_q;
   logic done_d;

   always_comb begin
      count_d = count_q;
      done_d = done_q;
      if (start) begin
         count_d = cycles - 4'h1;
         done_d = (cycles <= 4'h1);
      end else if (count_q != 4'h0) begin
         count_d = count_q - 4'h1;
         done_d = (count_q == 4'h1);
      end
   end

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         count_q <= 4'h0;
         done_q <= 1'b1;
      end else begin
         count_q <= count_d;
         done_q <= done_d;
      end
   end

   assign done = done_q;
endmodule

// file: rtl/vsc_top.sv
/*
 * Strobe selection and timing options for a video RAM controller. Holds the
 * programmed option bits, decodes bank selects into row and column strobes,
 * gates each column strobe by its extend input, and times the column strobe
 * against row hold, column setup and the write-delay option.
 * Assumes an APB master on clk_sys, and that the access sequencer supplies
 * accessStart, writeAccess, delayLineTrigger and accessEnd as one-cycle
 * pulses or levels synchronous to clk_sys.
 */
// Added by the designer: the APB slave port and the address map.
//
// Contract
// - write option 1: column strobe timed the same for read and write.
// - write option 0: write column strobe waits for delay line and next edge.
// - row-hold option 0 holds row address 25 ns, otherwise 15 ns.
// - column-setup option 0 gives 10 ns setup, 1 gives 0 ns (code rounds 1 up to one 5 ns cycle).
// - a column strobe asserts only while its own extend input is asserted (code registers the gate, so the strobe follows extend one cycle late).
// - code 000 selects all strobes, ignores bank selects, scrubs on refresh.
// - code 001 picks strobe pair by upper bank select, scrubs on refresh.
// - code 010 picks one row and column strobe by bank-select index, scrubs.
// - code 011 selects all strobes, refresh is row-strobe-only, no scrubbing.
module vsc_top (
   input wire logic clk_sys,
   input wire logic sys_rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic bankSelectLow,
   input wire logic bankSelectHigh,
   input wire logic [3:0] columnStrobeExtend,
   input wire logic accessStart,
   input wire logic writeAccess,
   input wire logic delayLineTrigger,
   input wire logic accessEnd,
   output logic [3:0] rowStrobe,
   output logic [3:0] colStrobe,
   output logic rowAddrSelect,
   output logic colAddrValid,
   output logic scrubEnable
);
   typedef enum logic [1:0] {
      StIdle = 2'b00,
      StRowHold = 2'b01,
      StColSetup = 2'b10,
      StColActive = 2'b11
   } vsc_state_t;

   logic [5:0] options_q;
   logic [5:0] options_d;
   logic programmed_q;
   logic programmed_d;
   logic [31:0] prdata_q;
   logic [31:0] prdata_d;
   logic pready_q;
   logic pready_d;
   logic pslverr_q;
   logic pslverr_d;

   vsc_state_t state_q;
   vsc_state_t state_d;
   logic [3:0] rowSel_q;
   logic [3:0] rowSel_d;
   logic [3:0] colSel_q;
   logic [3:0] colSel_d;
   logic isWrite_q;
   logic isWrite_d;
   logic trigSeen_q;
   logic trigSeen_d;
   logic edgeSeen_q;
   logic edgeSeen_d;
   logic [3:0] rowStrobe_q;
   logic [3:0] rowStrobe_d;
   logic [3:0] colStrobe_q;
   logic [3:0] colStrobe_d;
   logic rowAddr_q;
   logic rowAddr_d;
   logic colValid_q;
   logic colValid_d;
   logic scrub_q;
   logic scrub_d;

   logic [3:0] decRow;
   logic [3:0] decCol;
   logic decScrub;
   logic holdDone;
   logic setupDone;
   logic holdStart;
   logic setupStart;
   logic [vsc_pkg::CountWidth-1:0] holdCycles;
   logic [vsc_pkg::CountWidth-1:0] setupCycles;
   logic apbAccess;
   logic writeGate;

   function automatic logic [31:0] status_word(input logic prog, input logic scrub,
                                               input logic [3:0] ras, input logic [3:0] cas);
      logic [31:0] w;
      w = 32'h0000_0000;
      w[vsc_pkg::StatusProgBit] = prog;
      w[vsc_pkg::StatusScrubBit] = scrub;
      w[vsc_pkg::StatusRasLsb +: 4] = ras;
      w[vsc_pkg::StatusCasLsb +: 4] = cas;
      return w;
   endfunction

   vsc_strobe_decode u_decode (
      .configCode(options_q[vsc_pkg::ConfigLsb +: 3]),
      .bankSelectLow(bankSelectLow),
      .bankSelectHigh(bankSelectHigh),
      .rowSelect(decRow),
      .colSelect(decCol),
      .scrubRefresh(decScrub)
   );

   assign holdCycles = options_q[vsc_pkg::RowHoldBit] ?
      vsc_pkg::CountWidth'(vsc_pkg::RowHoldShortCyc) : vsc_pkg::CountWidth'(vsc_pkg::RowHoldLongCyc);
   assign setupCycles = options_q[vsc_pkg::ColumnSetupBit] ?
      vsc_pkg::CountWidth'(vsc_pkg::ColSetupShortCyc) : vsc_pkg::CountWidth'(vsc_pkg::ColSetupLongCyc);

   assign holdStart = (state_q == StIdle) && accessStart;
   assign setupStart = (state_q == StRowHold) && holdDone;

   vsc_delay_count u_hold (
      .clk_sys(clk_sys),
      .sys_rst(sys_rst),
      .start(holdStart),
      .cycles(holdCycles),
      .done(holdDone)
   );

   vsc_delay_count u_setup (
      .clk_sys(clk_sys),
      .sys_rst(sys_rst),
      .start(setupStart),
      .cycles(setupCycles),
      .done(setupDone)
   );

   assign apbAccess = psel && penable && !pready_q;

   // register bus: one wait state, answer on the second access cycle
   always_comb begin
      options_d = options_q;
      programmed_d = programmed_q;
      prdata_d = prdata_q;
      pready_d = 1'b0;
      pslverr_d = 1'b0;
      if (apbAccess) begin
         pready_d = 1'b1;
         prdata_d = 32'h0000_0000;
         case (paddr)
            vsc_pkg::OptionsAddr: begin
               if (pwrite) begin
                  options_d = pwdata[vsc_pkg::OptionsWidth-1:0];
                  programmed_d = 1'b1;
               end else begin
                  prdata_d = {26'h0, options_q};
               end
            end
            vsc_pkg::StatusAddr: begin
               if (!pwrite) begin
                  prdata_d = status_word(programmed_q, scrub_q, rowStrobe_q, colStrobe_q);
               end
            end
            default: begin
               pslverr_d = 1'b1;
            end
         endcase
      end
   end

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         options_q <= vsc_pkg::OptionsReset;
         programmed_q <= 1'b0;
         prdata_q <= 32'h0000_0000;
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
      end else begin
         options_q <= options_d;
         programmed_q <= programmed_d;
         prdata_q <= prdata_d;
         pready_q <= pready_d;
         pslverr_q <= pslverr_d;
      end
   end

   // write waits for delay line and clock edge only when option is 0
   assign writeGate = !isWrite_q || options_q[vsc_pkg::WriteStrobeBit] ||
      ((trigSeen_q || delayLineTrigger) && edgeSeen_q);

   always_comb begin
      state_d = state_q;
      rowSel_d = rowSel_q;
      colSel_d = colSel_q;
      isWrite_d = isWrite_q;
      trigSeen_d = trigSeen_q;
      edgeSeen_d = edgeSeen_q;
      rowStrobe_d = rowStrobe_q;
      colStrobe_d = 4'h0;
      rowAddr_d = rowAddr_q;
      colValid_d = colValid_q;
      scrub_d = decScrub;
      case (state_q)
         StIdle: begin
            rowStrobe_d = 4'h0;
            rowAddr_d = 1'b1;
            colValid_d = 1'b0;
            trigSeen_d = 1'b0;
            edgeSeen_d = 1'b0;
            if (accessStart) begin
               // bank selects sampled at access start
               rowSel_d = decRow;
               colSel_d = decCol;
               isWrite_d = writeAccess;
               rowStrobe_d = decRow;
               state_d = StRowHold;
            end
         end
         StRowHold: begin
            // first rising edge after row strobe
            edgeSeen_d = 1'b1;
            if (delayLineTrigger) begin
               trigSeen_d = 1'b1;
            end
            if (holdDone) begin
               rowAddr_d = 1'b0;
               colValid_d = 1'b1;
               state_d = StColSetup;
            end
         end
         StColSetup: begin
            if (delayLineTrigger) begin
               trigSeen_d = 1'b1;
            end
            if (setupDone && writeGate) begin
               colStrobe_d = colSel_q & columnStrobeExtend;
               state_d = StColActive;
            end
         end
         StColActive: begin
            // extend input keeps gating each cycle
            colStrobe_d = colSel_q & columnStrobeExtend;
            if (accessEnd) begin
               rowStrobe_d = 4'h0;
               colStrobe_d = 4'h0;
               colValid_d = 1'b0;
               state_d = StIdle;
            end
         end
         default: begin
            state_d = StIdle;
         end
      endcase
      if (accessEnd && state_q != StIdle) begin
         rowStrobe_d = 4'h0;
         colStrobe_d = 4'h0;
         colValid_d = 1'b0;
         state_d = StIdle;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         state_q <= StIdle;
         rowSel_q <= 4'h0;
         colSel_q <= 4'h0;
         isWrite_q <= 1'b0;
         trigSeen_q <= 1'b0;
         edgeSeen_q <= 1'b0;
         rowStrobe_q <= 4'h0;
         colStrobe_q <= 4'h0;
         rowAddr_q <= 1'b1;
         colValid_q <= 1'b0;
         scrub_q <= 1'b1;
      end else begin
         state_q <= state_d;
         rowSel_q <= rowSel_d;
         colSel_q <= colSel_d;
         isWrite_q <= isWrite_d;
         trigSeen_q <= trigSeen_d;
         edgeSeen_q <= edgeSeen_d;
         rowStrobe_q <= rowStrobe_d;
         colStrobe_q <= colStrobe_d;
         rowAddr_q <= rowAddr_d;
         colValid_q <= colValid_d;
         scrub_q <= scrub_d;
      end
   end

   assign prdata = prdata_q;
   assign pready = pready_q;
   assign pslverr = pslverr_q;
   assign rowStrobe = rowStrobe_q;
   assign colStrobe = colStrobe_q;
   assign rowAddrSelect = rowAddr_q;
   assign colAddrValid = colValid_q;
   assign scrubEnable = scrub_q;
endmodule

// file: sim/vsc_top_checker.sv
/* concurrent checks on the ports of vsc_top.
   assumes the single clk_sys domain and a bind to every vsc_top. */
module vsc_top_checker (
   input wire logic clk_sys,
   input wire logic sys_rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic pready,
   input wire logic bankSelectLow,
   input wire logic bankSelectHigh,
   input wire logic [3:0] columnStrobeExtend,
   input wire logic [3:0] rowStrobe,
   input wire logic [3:0] colStrobe,
   input wire logic rowAddrSelect,
   input wire logic colAddrValid,
   input wire logic scrubEnable
);
   timeunit 1ns;
   timeprecision 1ps;
   logic optWr;
   logic [2:0] code_q, code_d;
   logic [3:0] since_q, since_d;
   logic rowShort_q, rowShort_d;
   // option write is taken on the edge before pready shows
   assign optWr = psel && penable && !pready && pwrite && paddr == vsc_pkg::OptionsAddr;
   always_comb begin
      code_d = optWr ? pwdata[vsc_pkg::ConfigLsb +: 3] : code_q;
      rowShort_d = optWr ? pwdata[vsc_pkg::RowHoldBit] : rowShort_q;
      since_d = optWr ? 4'h0 : since_q + {3'h0, since_q != 4'hF};
   end
   always_ff @(posedge clk_sys) begin
      code_q <= sys_rst ? 3'h0 : code_d;
      rowShort_q <= sys_rst ? 1'b0 : rowShort_d;
      since_q <= sys_rst ? 4'hF : since_d;
   end
   default clocking @(posedge clk_sys); endclocking
   default disable iff (sys_rst);
   property p_rowHold;
      $rose(|rowStrobe) |-> rowAddrSelect [*3];
   endproperty
   a_rowHold: assert property (p_rowHold) else $error("row address released early");
   // long hold is five cycles of 5 ns
   property p_rowHoldLong;
      $rose(|rowStrobe) && !rowShort_q |-> rowAddrSelect [*5];
   endproperty
   a_rowHoldLong: assert property (p_rowHoldLong) else $error("long row hold cut short");
   property p_colSetup;
      |colStrobe |-> $past(colAddrValid) && !rowAddrSelect;
   endproperty
   a_colSetup: assert property (p_colSetup) else $error("column strobe without setup");
   property p_colGate;
      (colStrobe & ~$past(columnStrobeExtend)) == 4'h0;
   endproperty
   a_colGate: assert property (p_colGate) else $error("column strobe without extend");
   property p_allSel;
      $rose(|rowStrobe) && (code_q == 3'h0 || code_q == 3'h3) |-> rowStrobe == 4'hF;
   endproperty
   a_allSel: assert property (p_allSel) else $error("all-strobe select wrong");
   property p_pairSel;
      $rose(|rowStrobe) && code_q == 3'h1 |-> rowStrobe == ($past(bankSelectHigh) ? 4'hC : 4'h3);
   endproperty
   a_pairSel: assert property (p_pairSel) else $error("pair select wrong");
   property p_singleSel;
      $rose(|rowStrobe) && code_q == 3'h2 |-> rowStrobe == 4'h1 << {$past(bankSelectHigh), $past(bankSelectLow)};
   endproperty
   a_singleSel: assert property (p_singleSel) else $error("single select wrong");
   property p_scrub;
      since_q >= 4'h2 |-> scrubEnable == (code_q < 3'h3);
   endproperty
   a_scrub: assert property (p_scrub) else $error("scrub flag wrong for code");
   property p_optHold;
      $changed(scrubEnable) |-> since_q <= 4'h2;
   endproperty
   a_optHold: assert property (p_optHold) else $error("scrub flag moved without write");
   c_col: cover property ($rose(|colStrobe));
   c_hold: cover property ($fell(rowAddrSelect));
   c_opt: cover property (optWr);
endmodule
bind vsc_top vsc_top_checker chk_u (.*);

// file: sim/vsc_vram_model.sv
/* vram array seen from its strobe pins: measures row hold, column setup
   and row-to-column delay of each access. assumes strobes active high. */
module vsc_vram_model (
   input wire logic clk_sys,
   input wire logic [3:0] rowStrobe,
   input wire logic [3:0] colStrobe,
   input wire logic rowAddrSelect,
   input wire logic colAddrValid,
   output logic [7:0] holdCyc,
   output logic [7:0] setupCyc,
   output logic [7:0] casDelay
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] age;
   logic seen;
   // counts clear while no row strobe is up, so each access starts fresh
   always @(posedge clk_sys) begin
      if (rowStrobe == 4'h0) begin
         age <= 8'h0;
         holdCyc <= 8'h0;
         setupCyc <= 8'h0;
         seen <= 1'b0;
      end else begin
         age <= age + 8'h1;
         if (rowAddrSelect)
            holdCyc <= holdCyc + 8'h1;
         if (colAddrValid && colStrobe == 4'h0 && !seen)
            setupCyc <= setupCyc + 8'h1;
         if (colStrobe != 4'h0 && !seen) begin
            seen <= 1'b1;
            casDelay <= age;
         end
      end
   end
endmodule

// file: sim/vsc_top_tb.sv
/* self-checking bench for vsc_top: apb option writes, random accesses,
   strobe selection and timing measured by the vram model. */
module vsc_top_tb;
   timeunit 1ns;
   timeprecision 1ps;
`define CHK(nm, e, g) begin check_count++; if ((e) !== (g)) begin failures++; $display("ERROR %s exp %0h got %0h", nm, e, g); end end
   logic clk_sys = 1'b0, sys_rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic pready, pslverr, bankSelectLow = 1'b0, bankSelectHigh = 1'b0;
   logic accessStart = 1'b0, writeAccess = 1'b0, delayLineTrigger = 1'b0, accessEnd = 1'b0;
   logic [3:0] columnStrobeExtend = 4'h0, rowStrobe, colStrobe, rs;
   logic rowAddrSelect, colAddrValid, scrubEnable;
   logic [7:0] holdCyc, setupCyc, casDelay, hc, sc, rdDly;
   int failures = 0, check_count = 0;
   always #2.5 clk_sys = ~clk_sys;
   vsc_top dut_u (.*);
   vsc_vram_model vram_u (.*);
   function automatic logic [3:0] expSel(input logic [2:0] c, input logic h, input logic l);
      case (c)
         3'h1: return h ? 4'hC : 4'h3;
         3'h2: return 4'h1 << {h, l};
         default: return 4'hF;
      endcase
   endfunction
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, output logic err);
      int n;
      n = 0;
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_sys);
      penable <= 1'b1;
      do @(posedge clk_sys); while (pready !== 1'b1 && ++n < 50);
      if (pready !== 1'b1)
         failures++;
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk_sys);
   endtask
   // the window covers the slowest write, which waits for a late trigger
   task automatic access(input logic wr, input logic [3:0] ext, input int trig, output logic [3:0] cs);
      accessStart <= 1'b1;
      writeAccess <= wr;
      columnStrobeExtend <= ext;
      @(posedge clk_sys);
      accessStart <= 1'b0;
      for (int i = 1; i < 24; i++) begin
         delayLineTrigger <= (i == trig);
         @(posedge clk_sys);
      end
      cs = colStrobe;
      rs = rowStrobe;
      hc = holdCyc;
      sc = setupCyc;
      columnStrobeExtend <= 4'h0;
      repeat (2) @(posedge clk_sys);
      `CHK("colDrop", 4'h0, colStrobe)
      accessEnd <= 1'b1;
      @(posedge clk_sys);
      accessEnd <= 1'b0;
      repeat (2) @(posedge clk_sys);
   endtask
   task automatic end_of_test();
      if (failures == 0 && check_count > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   initial begin
      #100000;
      failures++;
      end_of_test();
   end
   initial begin
      logic err;
      logic [3:0] cs, sel;
      logic [2:0] code;
      logic [31:0] r;
      r = $urandom(32'h3276);
      repeat (4) @(posedge clk_sys);
      sys_rst <= 1'b0;
      apb(1'b0, vsc_pkg::OptionsAddr, 32'h0, err);
      `CHK("optRst", 32'h0, rd)
      `CHK("scrubRst", 1'b1, scrubEnable)
      apb(1'b0, 12'h0FC, 32'h0, err);
      `CHK("unmapErr", 1'b1, err)
      apb(1'b1, vsc_pkg::StatusAddr, 32'hFFFFFFFF, err);
      `CHK("roErr", 1'b0, err)
      for (int k = 0; k < 40; k++) begin
         r = $urandom();
         code = 3'(k % 4);
         apb(1'b1, vsc_pkg::OptionsAddr, {26'h0, r[2:0], code}, err);
         apb(1'b0, vsc_pkg::OptionsAddr, 32'h0, err);
         `CHK("optRd", {26'h0, r[2:0], code}, rd)
         `CHK("scrub", code != 3'h3, scrubEnable)
         apb(1'b0, vsc_pkg::StatusAddr, 32'h0, err);
         `CHK("status", {30'h0, code != 3'h3, 1'b1}, rd)
         bankSelectLow <= r[3];
         bankSelectHigh <= r[4];
         sel = expSel(code, r[4], r[3]);
         access(1'b0, r[8:5], 0, cs);
         `CHK("row", sel, rs)
         `CHK("col", sel & r[8:5], cs)
         `CHK("hold", 1'b1, hc >= (r[1] ? vsc_pkg::RowHoldShortCyc : vsc_pkg::RowHoldLongCyc))
         if ((sel & r[8:5]) != 4'h0) begin
            `CHK("setup", 1'b1, sc >= (r[0] ? vsc_pkg::ColSetupShortCyc : vsc_pkg::ColSetupLongCyc))
            rdDly = casDelay;
            access(1'b1, r[8:5], 2, cs);
            `CHK("wrSame", rdDly, casDelay)
            access(1'b1, r[8:5], 14, cs);
            if (r[2])
               `CHK("wrOpt", rdDly, casDelay)
            else
               `CHK("wrLate", 1'b1, casDelay >= 8'd14)
         end
      end
      sys_rst <= 1'b1;
      repeat (2) @(posedge clk_sys);
      sys_rst <= 1'b0;
      apb(1'b0, vsc_pkg::OptionsAddr, 32'h0, err);
      `CHK("optRst2", 32'h0, rd)
      end_of_test();
   end
endmodule
